// >>> core/ops_defines.svh
// Constants of the order phase sequencer
// Function
// - Three-bit phase field, 100 means first
// - Phases carry valid and increment flags
// - No instruction: dummies, phase unchanged
// - Function register loads only on 100
// - Short single: one valid phase 100
// - Short double: 100 no-inc, 111 inc
// - Short store-stack: push on 100, no name load
// - Short double: fetch 100, push store 111
// - Long single: dummy 100, valid 111
// - Unstack: pop on 100, address top on 111
// - Return-unstack: pointer becomes name base minus one
// - Long store-stack double: two phases
// - Long double: 100 dummy, 110, 111 store
// - Unstack operand double: no pointer load, store above
// - Long literal: two, three or five phases
// - Literal double: 100, 110, 111 or 101
// - Discard forces phase 000, contents invalid
// - Non-overlapped last phase sets lockout
// - Lockout holds function register and flags
// - Outside extra base: bypass, extra phase for a long-single or return-unstack descriptor
// - Name or line stores hold at stage 3
// - Base bus top bit zero, name forced
// - Waiting freezes the phase field outside phase 000
`ifndef OPS_DEFINES_SVH
`define OPS_DEFINES_SVH
// ****************************************
// Phase codes
// ****************************************
`define OPS_PH_DISCARD 3'h0
`define OPS_PH_FIRST 3'h4
`define OPS_PH_P111 3'h7
`define OPS_PH_P110 3'h6
`define OPS_PH_P101 3'h5
`define OPS_PH_P011 3'h3
`define OPS_PH_P001 3'h1
`define OPS_PH_P010 3'h2
// ****************************************
// Function half-word fields
// ****************************************
`define OPS_FN_TYPE_HI 15
`define OPS_FN_TYPE_LO 12
`define OPS_FN_UNSTACK 11
`define OPS_FN_NOVL 10
`define OPS_FN_DESC 9
`define OPS_FN_BSEL_HI 8
`define OPS_FN_BSEL_LO 7
`define OPS_FN_STORE 6
`define OPS_FN_BSTORE 5
`define OPS_FN_NZERO 4
`define OPS_FN_SHORT_HI 3
`define OPS_BSEL_NB 2'h0
`define OPS_BSEL_XB 2'h1
`define OPS_BSEL_STK 2'h2
// ****************************************
// Register offsets and reset values
// ****************************************
`define OPS_REG_CTRL 3'h0
`define OPS_REG_NB 3'h1
`define OPS_REG_XB 3'h2
`define OPS_REG_YB 3'h3
`define OPS_REG_STK 3'h4
`define OPS_REG_STAT 3'h5
`define OPS_CTRL_FORCE 0
`define OPS_CTRL_SEG_LO 16
`define OPS_CTRL_SEG_HI 29
`define OPS_RST_PTR 15'h0000
`define OPS_RST_SEG 14'h0000
`endif

// >>> core/ops_pkg.sv
// Types of the order phase sequencer
`include "ops_defines.svh"
package ops_pkg;
    typedef enum logic [3:0] {
        OT_SHORT_SINGLE = 4'h0,
        OT_SHORT_DOUBLE = 4'h1,
        OT_SHORT_STSTK = 4'h2,
        OT_LONG_SINGLE = 4'h3,
        OT_LONG_DOUBLE = 4'h4,
        OT_LONG_STSTK = 4'h5,
        OT_LIT16 = 4'h6,
        OT_LIT32 = 4'h7,
        OT_LIT64 = 4'h8,
        OT_LITD16 = 4'h9,
        OT_LITD32 = 4'hA,
        OT_LITD64 = 4'hB,
        OT_RET_UNSTACK = 4'hC
    } ops_order_type;
    typedef struct packed {
        logic [2:0] phase;
        logic [15:0] fn;
        logic [15:0] nm;
        logic bvalid;
        logic lock;
        logic force_novl;
        logic [13:0] seg;
        logic [14:0] nb;
        logic [14:0] xb;
        logic [13:0] yb;
        logic [14:0] stk;
        logic s1_valid;
        logic s1_inc;
        logic [2:0] s1_phase;
        logic [15:0] s1_fn;
        logic [16:0] s1_name;
        logic [14:0] s1_base;
        logic s1_lockreq;
        logic s1_hold;
        logic s1_st3hold;
        logic s1_bypass;
        logic ack;
        logic [31:0] dat;
    } ops_state_type;
endpackage

// >>> core/ops_sequencer.sv
// Stage-0 phase sequencer with Wishbone register slave
//
// Local design decisions: the Wishbone register port and the register offsets.
`include "ops_defines.svh"
module ops_sequencer
    import ops_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] ibu_halfword_i,
    input wire logic buffer_valid_i,
    input wire logic discard_i,
    input wire logic wait_i,
    input wire logic lockout_clear_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic stage1_valid_o,
    output logic stage1_increment_o,
    output logic [2:0] stage1_phase_o,
    output logic [15:0] stage1_function_o,
    output logic [16:0] name_bus_o,
    output logic [15:0] base_bus_o,
    output logic lockout_request_o,
    output logic hold_highway_o,
    output logic stage3_hold_o,
    output logic main_store_bypass_o,
    output logic lockout_bit_o,
    output logic [2:0] phase_o,
    output logic [14:0] stack_front_pointer_o
);
    ops_state_type r;
    ops_state_type n;
    ops_order_type typ;
    logic unst;
    logic novl;
    logic nzero;
    logic [1:0] bsel;
    logic [14:0] sel_base;
    logic bypass;
    logic long_type;
    logic valid;
    logic inc;
    logic last;
    logic hold;
    logic lockreq;
    logic push;
    logic [2:0] nph;
    logic [16:0] name;
    logic [14:0] base;
    logic wb_req;
    logic [31:0] wr_mask;
    logic [31:0] wval;

    // ****************************************
    // Phase sequencing and register slave
    // ****************************************
    always_comb begin
        n = r;
        typ = ops_order_type'(r.fn[`OPS_FN_TYPE_HI:`OPS_FN_TYPE_LO]);
        unst = r.fn[`OPS_FN_UNSTACK];
        novl = r.fn[`OPS_FN_NOVL] | r.force_novl;
        nzero = r.fn[`OPS_FN_NZERO];
        bsel = r.fn[`OPS_FN_BSEL_HI:`OPS_FN_BSEL_LO];
        case (bsel)
            `OPS_BSEL_NB: sel_base = r.nb;
            `OPS_BSEL_XB: sel_base = r.xb;
            default: sel_base = r.stk;
        endcase
        bypass = (bsel == `OPS_BSEL_XB) && (r.yb != r.seg);
        long_type = !(typ inside {OT_SHORT_SINGLE, OT_SHORT_DOUBLE, OT_SHORT_STSTK});
        valid = 1'b0;
        inc = 1'b1;
        last = 1'b0;
        hold = 1'b0;
        lockreq = 1'b0;
        push = 1'b0;
        nph = r.phase;
        name = nzero ? 17'h00000 : {1'b0, r.nm};
        base = sel_base;
        if (!long_type) begin
            name = {13'h0000, r.fn[`OPS_FN_SHORT_HI:0]};
        end
        if (r.phase == `OPS_PH_DISCARD) begin
            // Acts as a first phase on contents that are not trusted
            n.fn = ibu_halfword_i;
            n.bvalid = buffer_valid_i;
            nph = `OPS_PH_FIRST;
        end else if (wait_i) begin
            hold = 1'b1;
        end else if (r.phase == `OPS_PH_FIRST && (!r.bvalid || r.lock)) begin
            if (!r.lock) begin
                n.fn = ibu_halfword_i;
                n.bvalid = buffer_valid_i;
            end
        end else begin
            case (typ)
                OT_SHORT_DOUBLE, OT_SHORT_STSTK: begin
                    valid = 1'b1;
                    if (r.phase == `OPS_PH_FIRST) begin
                        inc = 1'b0;
                        nph = `OPS_PH_P111;
                        hold = 1'b1;
                        push = (typ == OT_SHORT_STSTK);
                    end else begin
                        last = 1'b1;
                        push = (typ == OT_SHORT_DOUBLE);
                    end
                end
                OT_LONG_SINGLE, OT_RET_UNSTACK: begin
                    if (r.phase == `OPS_PH_FIRST) begin
                        // An outside descriptor needs its operand back first
                        nph = (bypass && r.fn[`OPS_FN_DESC]) ? `OPS_PH_P110 : `OPS_PH_P111;
                        hold = nzero;
                        if (typ == OT_RET_UNSTACK) begin
                            n.stk = r.nb - 15'h0001;
                        end else if (unst) begin
                            n.stk = r.stk - 15'h0001;
                        end
                    end else if (r.phase == `OPS_PH_P110) begin
                        valid = 1'b1;
                        inc = 1'b0;
                        nph = `OPS_PH_P111;
                    end else begin
                        valid = 1'b1;
                        last = 1'b1;
                        if (unst) begin
                            base = r.stk;
                            name = 17'h00001;
                        end
                    end
                end
                OT_LONG_STSTK: begin
                    valid = 1'b1;
                    if (r.phase == `OPS_PH_FIRST) begin
                        inc = 1'b0;
                        push = 1'b1;
                        nph = `OPS_PH_P111;
                    end else begin
                        last = 1'b1;
                    end
                end
                OT_LONG_DOUBLE, OT_LITD16, OT_LITD32: begin
                    if (r.phase == `OPS_PH_FIRST) begin
                        nph = `OPS_PH_P110;
                    end else if (r.phase == `OPS_PH_P110) begin
                        valid = 1'b1;
                        inc = 1'b0;
                        hold = (typ == OT_LONG_DOUBLE);
                        nph = `OPS_PH_P111;
                    end else begin
                        valid = 1'b1;
                        push = 1'b1;
                        last = 1'b1;
                    end
                end
                OT_LITD64: begin
                    case (r.phase)
                        `OPS_PH_FIRST: nph = `OPS_PH_P110;
                        `OPS_PH_P110: begin
                            valid = 1'b1;
                            inc = 1'b0;
                            nph = `OPS_PH_P101;
                        end
                        `OPS_PH_P101: begin
                            valid = 1'b1;
                            push = 1'b1;
                            nph = `OPS_PH_P010;
                        end
                        `OPS_PH_P010: nph = `OPS_PH_P011;
                        default: last = 1'b1;
                    endcase
                end
                OT_LIT16, OT_LIT32, OT_LIT64: begin
                    case (r.phase)
                        `OPS_PH_FIRST: begin
                            nph = (typ == OT_LIT16) ? `OPS_PH_P111 : `OPS_PH_P110;
                        end
                        `OPS_PH_P110: begin
                            valid = 1'b1;
                            nph = (typ == OT_LIT64) ? `OPS_PH_P001 : `OPS_PH_P011;
                        end
                        `OPS_PH_P111: begin
                            valid = 1'b1;
                            last = 1'b1;
                        end
                        `OPS_PH_P001: nph = `OPS_PH_P010;
                        `OPS_PH_P010: nph = `OPS_PH_P011;
                        default: last = 1'b1;
                    endcase
                end
                default: begin
                    valid = 1'b1;
                    last = 1'b1;
                end
            endcase
            if (push) begin
                if (unst) begin
                    base = r.stk;
                    name = 17'h00001;
                end else begin
                    n.stk = r.stk + 15'h0001;
                    base = r.stk + 15'h0001;
                    name = 17'h00000;
                end
            end
            if (last) begin
                nph = `OPS_PH_FIRST;
                if (novl) begin
                    n.lock = 1'b1;
                    n.bvalid = 1'b0;
                    lockreq = 1'b1;
                    hold = 1'b1;
                end else begin
                    n.fn = ibu_halfword_i;
                    n.bvalid = buffer_valid_i;
                end
            end
            if (nph != `OPS_PH_FIRST && long_type && !nzero) begin
                n.nm = ibu_halfword_i;
            end
        end
        n.phase = nph;
        n.s1_valid = valid;
        n.s1_inc = inc;
        n.s1_phase = r.phase;
        n.s1_fn = r.fn;
        n.s1_name = name;
        n.s1_base = base;
        n.s1_st3hold = valid && r.fn[`OPS_FN_STORE] && !r.fn[`OPS_FN_BSTORE];
        n.s1_bypass = valid && bypass;
        if (!r.lock) begin
            n.s1_lockreq = lockreq;
            n.s1_hold = hold;
        end
        if (lockout_clear_i && !lockreq) begin
            n.lock = 1'b0;
            n.s1_lockreq = 1'b0;
            n.s1_hold = 1'b0;
        end
        if (discard_i) begin
            n.phase = `OPS_PH_DISCARD;
            n.lock = 1'b0;
            n.bvalid = 1'b0;
            n.s1_valid = 1'b0;
            n.s1_lockreq = 1'b0;
            n.s1_hold = 1'b0;
            n.s1_st3hold = 1'b0;
            n.s1_bypass = 1'b0;
        end
        // Software pointer writes take priority over sequencer updates
        wb_req = wb_cyc_i && wb_stb_i && !r.ack;
        n.ack = wb_req;
        wr_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        wval = 32'h00000000;
        case (wb_adr_i[4:2])
            `OPS_REG_CTRL: wval = {2'h0, r.seg, 15'h0000, r.force_novl};
            `OPS_REG_NB: wval = {17'h00000, r.nb};
            `OPS_REG_XB: wval = {17'h00000, r.xb};
            `OPS_REG_YB: wval = {18'h00000, r.yb};
            `OPS_REG_STK: wval = {17'h00000, r.stk};
            `OPS_REG_STAT: wval = {27'h0000000, r.bvalid, r.lock, r.phase};
            default: wval = 32'h00000000;
        endcase
        if (wb_adr_i[7:5] != 3'h0) begin
            wval = 32'h00000000;
        end
        n.dat = wb_req ? wval : 32'h00000000;
        if (wb_req && wb_we_i && wb_adr_i[7:5] == 3'h0) begin
            wval = (wval & ~wr_mask) | (wb_dat_i & wr_mask);
            case (wb_adr_i[4:2])
                `OPS_REG_CTRL: begin
                    n.force_novl = wval[`OPS_CTRL_FORCE];
                    n.seg = wval[`OPS_CTRL_SEG_HI:`OPS_CTRL_SEG_LO];
                end
                `OPS_REG_NB: n.nb = wval[14:0];
                `OPS_REG_XB: n.xb = wval[14:0];
                `OPS_REG_YB: n.yb = wval[13:0];
                `OPS_REG_STK: n.stk = wval[14:0];
                default: n.dat = n.dat;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.phase <= `OPS_PH_DISCARD;
            r.nb <= `OPS_RST_PTR;
            r.xb <= `OPS_RST_PTR;
            r.stk <= `OPS_RST_PTR;
            r.yb <= `OPS_RST_SEG;
            r.seg <= `OPS_RST_SEG;
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign wb_dat_o = r.dat;
    assign wb_ack_o = r.ack;
    assign stage1_valid_o = r.s1_valid;
    assign stage1_increment_o = r.s1_inc;
    assign stage1_phase_o = r.s1_phase;
    assign stage1_function_o = r.s1_fn;
    assign name_bus_o = r.s1_name;
    assign base_bus_o = {1'b0, r.s1_base};
    assign lockout_request_o = r.s1_lockreq;
    assign hold_highway_o = r.s1_hold;
    assign stage3_hold_o = r.s1_st3hold;
    assign main_store_bypass_o = r.s1_bypass;
    assign lockout_bit_o = r.lock;
    assign phase_o = r.phase;
    assign stack_front_pointer_o = r.stk;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_discard_phase: assert property (discard_i |=> r.phase == `OPS_PH_DISCARD && !r.lock)
        else $error("discard did not force phase 000");
    // The strobe lands together with the return to 100
    a_fn_load_first: assert property (!$stable(r.fn) |-> r.phase inside
        {`OPS_PH_FIRST, `OPS_PH_DISCARD})
        else $error("function register loaded outside first phase");
    a_idle_stays: assert property (r.phase == `OPS_PH_FIRST && !r.bvalid && !discard_i
        |=> r.phase == `OPS_PH_FIRST && !stage1_valid_o)
        else $error("phase moved without a valid instruction");
    a_wait_freeze: assert property (wait_i && !discard_i && r.phase != `OPS_PH_DISCARD
        |=> $stable(r.phase) && !stage1_valid_o)
        else $error("phase changed while waiting");
    a_lock_holds: assert property (r.lock && !discard_i && !lockout_clear_i
        |=> $stable(r.fn) && $stable(lockout_request_o))
        else $error("locked function register changed");
    a_noinc_phase: assert property (stage1_valid_o && !stage1_increment_o
        |-> stage1_phase_o inside {`OPS_PH_FIRST, `OPS_PH_P110})
        else $error("increment cleared on a wrong phase");
    a_short_one: assert property (r.phase == `OPS_PH_FIRST && r.bvalid && !r.lock
        && r.fn[15:12] == 4'h0 && !r.fn[10] && !r.force_novl && !wait_i && !discard_i
        |=> stage1_valid_o && stage1_increment_o && r.phase == `OPS_PH_FIRST)
        else $error("short single order not one phase");
    a_short_double: assert property (r.phase == `OPS_PH_FIRST && r.bvalid && !r.lock
        && r.fn[15:12] == 4'h1 && !wait_i && !discard_i
        |=> stage1_valid_o && !stage1_increment_o && r.phase == `OPS_PH_P111)
        else $error("short double first part wrong");
    a_lock_set: assert property ($rose(r.lock) |-> lockout_request_o && !r.bvalid
        && r.phase == `OPS_PH_FIRST)
        else $error("lockout set without request");
    a_base_top: assert property (!base_bus_o[15])
        else $error("base bus top bit set");
    a_wb_ack: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    c_short_double: cover property (r.phase == `OPS_PH_P111 ##1 stage1_valid_o);
    c_lockout: cover property ($rose(r.lock));
    c_lit64_tail: cover property (r.phase == `OPS_PH_P001 ##1 r.phase == `OPS_PH_P010);
    c_discard: cover property (discard_i ##1 r.phase == `OPS_PH_DISCARD);
endmodule

// >>> sim/ops_ibu_model.sv
// Behavioural instruction buffer unit feeding half-words to the sequencer
module ops_ibu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    output logic [15:0] halfword_o = 16'h0000,
    output logic valid_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] fifo[$];
    task automatic push(input logic [15:0] w);
        fifo.push_back(w);
    endtask
    task automatic flush;
        fifo.delete();
    endtask
    // One half-word per beat; a stall keeps the gated word on the highway
    always @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            halfword_o <= 16'h0000;
        end else if (stall_i && valid_o) begin
            valid_o <= 1'b1;
        end else if (fifo.size() != 0) begin
            halfword_o <= fifo.pop_front();
            valid_o <= 1'b1;
        end else begin
            // Empty highway toggles so a stale word never looks valid
            halfword_o <= ~halfword_o;
            valid_o <= 1'b0;
        end
    end
endmodule

// >>> sim/ops_sequencer_bench.sv
// Self-checking bench of the order phase sequencer
`include "ops_defines.svh"
module ops_sequencer_bench
    import ops_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Per type: stage-1 keys {valid,inc,phase}, key count, beats, stack step
    // ********
    localparam logic [19:0] KEYS [13] = '{20'h0001C, 20'h003F4, 20'h003F4, 20'h0001F,
        20'h003F6, 20'h003F4, 20'h0001F, 20'h0017E, 20'h5A93E, 20'h003F6, 20'h003F6,
        20'h5ABB6, 20'h0001F};
    localparam int NKEY [13] = '{1, 2, 2, 1, 2, 2, 1, 2, 4, 2, 2, 4, 1};
    localparam int NBEAT [13] = '{1, 2, 2, 2, 3, 2, 2, 3, 5, 3, 3, 5, 2};
    localparam int SFD [13] = '{0, 1, 1, 0, 1, 1, 0, 0, 0, 1, 1, 1, 0};
    localparam logic [14:0] NB_VAL = 15'h0123;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic disc = 1'b0;
    logic wt = 1'b0;
    logic lclr = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [15:0] hw;
    logic hv;
    logic [31:0] rd;
    logic ack;
    logic s1v;
    logic s1i;
    logic [2:0] s1p;
    logic [15:0] bbus;
    logic lreq;
    logic hhw;
    logic lbit;
    logic [2:0] ph;
    logic [2:0] held;
    logic [14:0] sfp;
    logic [15:0] s1f;
    logic [16:0] nbus;
    logic s3h;
    logic msb;
    logic [1:0] side;
    logic [4:0] key;
    logic [31:0] got;
    logic mon_en = 1'b0;
    logic [4:0] exp_q[$];
    logic [14:0] exp_stk = 15'h0000;
    ops_order_type t;
    logic u;
    int seed = 95876;
    int checked = 0;
    int mismatches = 0;
    int cycles = 0;
    int n;
    always #20 clk = ~clk;
    ops_sequencer u_ops_sequencer (
        .clk_i(clk), .rst_i(rst), .ibu_halfword_i(hw), .buffer_valid_i(hv),
        .discard_i(disc), .wait_i(wt), .lockout_clear_i(lclr), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rd), .wb_ack_o(ack), .stage1_valid_o(s1v), .stage1_increment_o(s1i),
        .stage1_phase_o(s1p), .stage1_function_o(s1f), .name_bus_o(nbus), .base_bus_o(bbus),
        .lockout_request_o(lreq), .hold_highway_o(hhw), .stage3_hold_o(s3h),
        .main_store_bypass_o(msb), .lockout_bit_o(lbit), .phase_o(ph),
        .stack_front_pointer_o(sfp));
    ops_ibu_model u_ibu_model (.clk_i(clk), .rst_i(rst), .stall_i(wt), .halfword_o(hw),
        .valid_o(hv));
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic results;
        $display("Checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1);
        got = rd;
        check("wishbone latency", 32'h2, 32'(k));
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    function automatic int expect_order(input ops_order_type ty, input logic un);
        int i;
        i = int'(ty);
        for (int k = 0; k < NKEY[i]; k++) exp_q.push_back(KEYS[i][5*k +: 5]);
        if (ty == OT_RET_UNSTACK) exp_stk = NB_VAL - 15'h0001;
        else if (un && ty == OT_LONG_SINGLE) exp_stk = exp_stk - 15'h0001;
        else if (!un) exp_stk = exp_stk + 15'(SFD[i]);
        return NBEAT[i];
    endfunction
    // Phases that address the stack top for a push or an unstack
    function automatic logic push_ph(input logic [15:0] f, input logic [2:0] p);
        case (ops_order_type'(f[`OPS_FN_TYPE_HI:`OPS_FN_TYPE_LO]))
            OT_SHORT_STSTK, OT_LONG_STSTK: return p == `OPS_PH_FIRST;
            OT_SHORT_DOUBLE, OT_LONG_DOUBLE, OT_LITD16, OT_LITD32: return p == `OPS_PH_P111;
            OT_LITD64: return p == `OPS_PH_P101;
            OT_LONG_SINGLE: return f[`OPS_FN_UNSTACK] && p == `OPS_PH_P111;
            default: return 1'b0;
        endcase
    endfunction
    task automatic issue(input ops_order_type ty, input logic un, input logic novl);
        logic [15:0] fn;
        int beats;
        fn = 16'($random(seed));
        fn[15:12] = ty;
        fn[11] = un;
        fn[10] = novl;
        fn[9] = 1'b0;
        fn[4] = 1'b0;
        if (fn[8:7] == 2'h3) fn[8:7] = `OPS_BSEL_NB;
        u_ibu_model.push(fn);
        beats = expect_order(ty, un);
        repeat (beats - 1) u_ibu_model.push(16'($random(seed)));
    endtask
    task automatic drain;
        int k;
        k = 0;
        while (u_ibu_model.fifo.size() != 0 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        repeat (8) @(posedge clk);
        check("pending phases", 32'h0, 32'(exp_q.size()));
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            $display("Error run timed out");
            mismatches++;
            results();
        end
    end
    // Dummies at 100 or 000 are skipped; idle beats look the same
    always @(posedge clk) begin
        key = {s1v, s1i, s1p};
        side = {s1v & s1f[`OPS_FN_STORE] & !s1f[`OPS_FN_BSTORE],
            s1v & (s1f[`OPS_FN_BSEL_HI:`OPS_FN_BSEL_LO] == `OPS_BSEL_XB)};
        if (mon_en === 1'b1) begin
            if (s1v === 1'b1 || (s1p[2] === 1'b0 && s1p !== 3'h0)) begin
                if (exp_q.size() == 0) check("unexpected phase", 32'hFFFF_FFFF, 32'(key));
                else check("stage1 phase", 32'(exp_q.pop_front()), 32'(key));
            end
            check("base bus top bit", 32'h0, 32'(bbus[15]));
            if (s1v === 1'b1 && push_ph(s1f, s1p)) begin
                check("stack name", 32'(s1f[`OPS_FN_UNSTACK]), 32'(nbus));
            end
            check("stage3 hold", 32'(side[1]), 32'(s3h));
            check("store bypass", 32'(side[0]), 32'(msb));
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        check("reset phase", 32'(`OPS_PH_DISCARD), 32'(ph));
        check("reset lockout", 32'h0, 32'(lbit));
        @(posedge clk);
        for (int a = 4; a < 16; a += 4) begin
            wb(1'b0, 8'(a), 32'h0);
            check("register reset", 32'h0, got);
        end
        wb(1'b1, 8'h04, {17'h0, NB_VAL});
        wb(1'b0, 8'h04, 32'h0);
        check("name base", {17'h0, NB_VAL}, got);
        // Extra base outside the name segment, so its orders bypass
        wb(1'b1, 8'h0C, 32'h0000_0001);
        wb(1'b1, 8'h18, 32'hFFFF_FFFF);
        wb(1'b0, 8'h18, 32'h0);
        check("unmapped", 32'h0, got);
        wb(1'b0, 8'h14, 32'h0);
        check("idle status", 32'(`OPS_PH_FIRST), got);
        mon_en <= 1'b1;
        repeat (3) begin
            @(posedge clk);
            check("idle phase", 32'(`OPS_PH_FIRST), 32'(ph));
            check("idle valid", 32'h0, 32'(s1v));
        end
        for (int k = 0; k < 13; k++) issue(ops_order_type'(4'(k)), 1'b0, 1'b0);
        issue(OT_LONG_SINGLE, 1'b1, 1'b0);
        issue(OT_LONG_DOUBLE, 1'b1, 1'b0);
        drain();
        check("stack front", 32'(exp_stk), 32'(sfp));
        repeat (60) begin
            t = ops_order_type'(4'({$random(seed)} % 13));
            u = (t == OT_LONG_SINGLE || t == OT_LONG_DOUBLE) ? 1'($random(seed)) : 1'b0;
            issue(t, u, 1'b0);
        end
        drain();
        check("stack front", 32'(exp_stk), 32'(sfp));
        issue(OT_LONG_DOUBLE, 1'b0, 1'b0);
        n = 0;
        while (ph !== `OPS_PH_P110 && n < 20) begin
            @(posedge clk);
            n++;
        end
        wt <= 1'b1;
        @(posedge clk);
        held = ph;
        repeat (3) begin
            @(posedge clk);
            check("frozen phase", 32'(held), 32'(ph));
            check("waiting valid", 32'h0, 32'(s1v));
        end
        wt <= 1'b0;
        drain();
        issue(OT_SHORT_SINGLE, 1'b0, 1'b1);
        repeat (6) @(posedge clk);
        check("lockout bit", 32'h1, 32'(lbit));
        check("lockout request", 32'h1, 32'(lreq));
        u_ibu_model.push(16'h0000);
        repeat (5) @(posedge clk);
        check("held highway", 32'h1, 32'(hhw));
        lclr <= 1'b1;
        @(posedge clk);
        lclr <= 1'b0;
        repeat (2) @(posedge clk);
        check("lockout bit", 32'h0, 32'(lbit));
        issue(OT_SHORT_SINGLE, 1'b0, 1'b0);
        drain();
        mon_en <= 1'b0;
        issue(OT_LIT64, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        u_ibu_model.flush();
        disc <= 1'b1;
        @(posedge clk);
        disc <= 1'b0;
        @(posedge clk);
        check("discard phase", 32'(`OPS_PH_DISCARD), 32'(ph));
        exp_q.delete();
        mon_en <= 1'b1;
        issue(OT_SHORT_DOUBLE, 1'b0, 1'b0);
        drain();
        results();
    end
endmodule
